// ===== bench/mac_port_sva.sv
/*
  Checker of the MAC port outputs against the link and bus inputs.
  Assumes the package is compiled first and the bind below.
*/
`timescale 1ns/1ps
module mac_port_sva
  import mac_port_pkg::*;
(
  input logic sys_clk,
  input logic rst_b,
  input logic hreadyout,
  input logic hresp,
  input logic rx_dv,
  input phy_tx_t phy_tx,
  input logic tx_take,
  input logic tx_retry,
  input logic tx_abort,
  input rx_word_t rx_word
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_en_with_take: assert property ($rose(phy_tx.en) |-> tx_take)
    else $error("enable rose without a take");
  chk_take_drives: assert property (tx_take |-> phy_tx.en)
    else $error("take while enable low");
  chk_take_single: assert property (tx_take |=> !tx_take)
    else $error("take longer than one cycle");
  chk_abort_quiet: assert property (tx_abort |-> ##[0:2] !phy_tx.en)
    else $error("enable stays up after abort");
  chk_abort_single: assert property (tx_abort |=> (!tx_abort) [*4])
    else $error("abort repeated");
  chk_retry_idle: assert property (tx_retry |-> !phy_tx.en && !tx_abort)
    else $error("retry while sending or aborting");
  chk_rx_needs_dv: assert property (rx_word.valid |->
    $past(rx_dv, 2) || $past(rx_dv, 3) || $past(rx_dv, 4))
    else $error("word without data valid");
  chk_rx_single: assert property (rx_word.valid |=> !rx_word.valid)
    else $error("receive word longer than one cycle");
  chk_ready_up: assert property (rst_b && $past(rst_b) && $past(rst_b, 2) |-> hreadyout)
    else $error("bus not ready after reset");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  cover property (tx_retry);
  cover property (tx_abort);
  cover property (rx_word.valid);
  cover property ($rose(phy_tx.en));
endmodule

bind mac_port mac_port_sva chk (.sys_clk(sys_clk), .rst_b(rst_b), .hreadyout(hreadyout),
  .hresp(hresp), .rx_dv(rx_dv), .phy_tx(phy_tx), .tx_take(tx_take), .tx_retry(tx_retry),
  .tx_abort(tx_abort), .rx_word(rx_word));

// ===== bench/mii_rmii_mac_port_with_abort_counters_bench.sv
/*
  Bench of the MAC port: bus tasks, frame source, link monitor.
  Assumes the package, checker and PHY model compiled before it.
*/
`timescale 1ns/1ps
module mii_rmii_mac_port_with_abort_counters_bench
  import mac_port_pkg::*;
;
  localparam int LEN = 8;
  localparam logic [31:0] A_UNDR = 32'h00000CDC;
  localparam logic [31:0] A_ALL = 32'h00000CE0;
  localparam logic [31:0] A_CTRL = 32'h00000D00;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, tx_clk_out, tx_take, tx_retry, tx_abort, mon_clk;
  logic lclk, tx_clk_in, sref, col, crs, rx_dv, rx_er;
  logic col_req = 1'b0;
  logic run = 1'b0;
  logic [3:0] rxd;
  logic [3:0] ctl = 4'h0;
  logic [31:0] hrdata;
  phy_tx_t phy_tx;
  rx_word_t rx_word;
  tx_src_t tx_src = '0;
  logic [4:0] txq [$];
  logic [4:0] rxq [$];
  logic [4:0] exq [$];
  logic [3:0] modes [0:3] = '{4'h0, 4'h4, 4'h3, 4'h1};
  int miscompares = 0;
  int cmp_count = 0;
  int idx = 0;
  int gap = -1;
  int retries = 0;
  int aborts = 0;
  int ni, m, i, j, n, v;

  always #4 sys_clk = ~sys_clk;
  assign hready = hreadyout;
  // Monitor clock follows the mode; mode changes only between frames
  assign mon_clk = ctl[0] ? lclk : (ctl[2] ? tx_clk_out : tx_clk_in);

  mac_port #(.MAX_ATTEMPTS(3), .RMII_10M_DIV(10)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_clk_in(tx_clk_in), .system_reference_clock_in(sref),
    .ref_clk(lclk), .rx_clk(lclk), .col(col), .crs(crs), .rx_dv(rx_dv), .rx_er(rx_er),
    .rxd(rxd), .tx_clk_out(tx_clk_out), .phy_tx(phy_tx), .tx_src(tx_src),
    .tx_take(tx_take), .tx_retry(tx_retry), .tx_abort(tx_abort), .rx_word(rx_word));
  phy_model phy (.lclk(lclk), .tx_clk_in(tx_clk_in), .sref(sref), .col(col), .crs(crs),
    .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .tx_en(phy_tx.en), .col_req(col_req));

  // ----------------------------------------
  // Frame source and monitors
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    ni = !run ? 0 : (tx_retry ? 0 : (tx_take ? idx + 1 : idx));
    idx <= ni;
    retries <= retries + int'(tx_retry);
    aborts <= aborts + int'(tx_abort);
    if (tx_abort === 1'b1)
      run <= 1'b0;
    tx_src.valid <= run && tx_abort !== 1'b1 && ni < LEN && ni != gap;
    tx_src.last <= (ni == LEN - 1);
    tx_src.nibble <= 4'h8 | ni[3:0];
  end
  always @(negedge mon_clk)
    if (phy_tx.en === 1'b1)
      txq.push_back({1'b0, phy_tx.d});
  always @(posedge sys_clk)
    if (rx_word.valid === 1'b1)
      rxq.push_back({rx_word.dibit, rx_word.dibit ? {2'h0, rx_word.data[1:0]} : rx_word.data});

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        miscompares++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chkq(input logic [4:0] got [$], input logic [4:0] exp [$]);
    int k;
    begin
      cmp(got.size(), exp.size());
      for (k = 0; k < got.size() && k < exp.size(); k++)
        cmp({27'h0, got[k]}, {27'h0, exp[k]});
    end
  endtask
  task hwait;
    int k;
    begin
      k = 0;
      @(posedge sys_clk);
      while (hready !== 1'b1 && k < 99)
      begin
        @(posedge sys_clk);
        k++;
      end
      // A bus that never answers counts against the run
      if (hready !== 1'b1)
        miscompares++;
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] r);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hwait;
      htrans <= 2'h0;
      hwdata <= d;
      hwait;
      r = hrdata;
    end
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    begin
      bus(1'b0, a, 32'h0, r);
      cmp(r, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    begin
      bus(1'b1, a, d, r);
      @(posedge sys_clk);
    end
  endtask
  task send;
    int k;
    logic seen;
    begin
      txq.delete();
      seen = 1'b0;
      run <= 1'b1;
      for (k = 0; k < 20000 && !(seen && phy_tx.en !== 1'b1 && (idx >= LEN || !run)); k++)
      begin
        @(posedge sys_clk);
        seen = seen | (phy_tx.en === 1'b1);
      end
      if (k >= 20000)
        miscompares++;
      run <= 1'b0;
      repeat (20) @(posedge sys_clk);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    #400000;
    miscompares++;
    test_done;
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(A_ALL, 32'h0);
    rd(A_UNDR, 32'h0);
    rd(A_CTRL, 32'h0);
    rd(32'h00000004, 32'h0);
    $display("test reset_values done");
    for (m = 0; m < 4; m++)
    begin
      ctl = modes[m];
      col_req <= (m == 0);
      wr(A_CTRL, {28'h0, ctl});
      send;
      exq.delete();
      n = (ctl == 4'h1) ? 10 : 1;
      for (i = 0; i < LEN * n * (ctl[0] ? 2 : 1); i++)
      begin
        j = i / n;
        v = ctl[0] ? ((8 | j / 2) >> (2 * (j % 2))) & 3 : 8 | j;
        exq.push_back(v[4:0]);
      end
      chkq(txq, exq);
      if (m % 2 == 0)
      begin
        rxq.delete();
        exq.delete();
        phy.burst(6, 1'b0);
        if (m == 0)
          phy.burst(4, 1'b1);
        repeat (20) @(posedge sys_clk);
        for (i = 0; i < 6; i++)
        begin
          v = i + 3;
          exq.push_back(ctl[0] ? {3'h4, v[1:0]} : {1'b0, v[3:0]});
        end
        chkq(rxq, exq);
      end
      $display("test mode %0d done", m);
    end
    ctl = 4'h0;
    wr(A_CTRL, 32'h0);
    gap = 3;
    send;
    gap = -1;
    cmp(aborts, 1);
    $display("test underrun done");
    col_req <= 1'b1;
    ctl = 4'h8;
    wr(A_CTRL, 32'h00000008);
    send;
    n = 0;
    foreach (txq[k])
      n += int'(txq[k] == 5'h05);
    cmp(n, 24);
    cmp(retries, 2);
    cmp(aborts, 2);
    col_req <= 1'b0;
    $display("test collision done");
    rd(A_UNDR, 32'h1);
    rd(32'h00000CD0, 32'h1);
    rd(A_ALL, 32'h2);
    rd(A_CTRL, 32'h8);
    rd(32'h00000D04, 32'h0);
    wr(A_ALL, 32'hFFFFFFFF);
    rd(A_ALL, 32'h2);
    $display("test counters done");
    test_done;
  end
endmodule

// ===== bench/phy_model.sv
/*
  PHY partner: free link clocks, carrier, collision and receive bursts.
  Assumes the bench calls burst between frames.
*/
`timescale 1ns/1ps
module phy_model
(
  output logic lclk,
  output logic tx_clk_in,
  output logic sref,
  output logic col,
  output logic crs,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd,
  input logic tx_en,
  input logic col_req
);
  // ----------------------------------------
  // Clocks off the system edges
  // ----------------------------------------
  initial
  begin
    lclk = 1'b0;
    tx_clk_in = 1'b0;
    sref = 1'b0;
    rx_dv = 1'b0;
    rx_er = 1'b0;
    rxd = 4'hA;
  end
  initial
  begin
    #3;
    forever #40 lclk = ~lclk;
  end
  initial
  begin
    #11;
    forever #40 tx_clk_in = ~tx_clk_in;
  end
  initial
  begin
    #27;
    forever #40 sref = ~sref;
  end
  assign crs = tx_en | rx_dv;
  assign col = col_req & tx_en;
  task burst(input int n, input logic er);
    int i;
    begin
      for (i = 0; i < n; i++)
      begin
        @(negedge lclk);
        rx_dv = 1'b1;
        rx_er = er;
        rxd = i[3:0] + 4'h3;
      end
      @(negedge lclk);
      // Off the system clock edges so the sampling flops never race the pin
      #14;
      rx_dv = 1'b0;
      rx_er = 1'b0;
      rxd = ~rxd;
    end
  endtask
endmodule

// ===== design/mac_port.sv
/*
  MII/RMII MAC port with half-duplex collision handling and two transmit abort counters,
  registers on an AHB-Lite slave.
  Assumes one 125 MHz clock; all PHY pins and link clocks are asynchronous and sampled.
*/
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps

module mac_port
  import mac_port_pkg::*;
#(
  parameter int MAX_ATTEMPTS = 16,
  parameter int RMII_10M_DIV = 10
)
(
  input logic sys_clk,
  input logic rst_b,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic tx_clk_in,
  input logic system_reference_clock_in,
  input logic ref_clk,
  input logic rx_clk,
  input logic col,
  input logic crs,
  input logic rx_dv,
  input logic rx_er,
  input logic [3:0] rxd,
  output logic tx_clk_out,
  output phy_tx_t phy_tx,
  input tx_src_t tx_src,
  output logic tx_take,
  output logic tx_retry,
  output logic tx_abort,
  output rx_word_t rx_word
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (MAX_ATTEMPTS < 1 || MAX_ATTEMPTS > 31)
  begin : g_att_check
    $error("MAX_ATTEMPTS must lie in 1..31");
  end
  if (RMII_10M_DIV < 2 || RMII_10M_DIV > 16)
  begin : g_div_check
    $error("RMII_10M_DIV must lie in 2..16");
  end

  localparam logic [4:0] ATT_MAX = 5'(MAX_ATTEMPTS);
  localparam logic [3:0] DIV_LAST = 4'(RMII_10M_DIV - 1);

  mac_state_t s;
  mac_state_t n;
  logic [1:0] rst_pipe;
  logic rst_int_b;
  logic mii_step;
  logic ref_slot;
  logic step;
  logic col_hd;
  logic crs_hd;
  logic [4:0] jam_last;
  logic [4:0] bo_bits;
  logic [17:0] bo_k;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic rise(input logic [`SYN_W-1:0] now, input logic [`SYN_W-1:0] old,
                                input int b);
    return now[b] & ~old[b];
  endfunction

  // Low dibit goes first in RMII
  function automatic logic [3:0] drive(input logic [3:0] nib, input logic rmii,
                                       input logic hi);
    if (!rmii)
      return nib;
    return {2'b00, (hi ? nib[3:2] : nib[1:0])};
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction

  function automatic logic [31:0] read_reg(input logic [9:0] idx, input mac_state_t r);
    case (idx)
      `IDX_UNDR_LOW: return {24'h000000, r.undr[7:0]};
      `IDX_UNDR_FULL: return r.undr;
      `IDX_ALL: return r.all;
      `IDX_CTRL: return {28'h0000000, r.ctrl};
      `IDX_STATUS: return {24'h000000, r.attempts, r.tst, r.tx.en};
      default: return 32'h00000000;
    endcase
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_int_b = rst_pipe[1];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = s;
    // Data and clocks share one pipeline so they stay aligned
    n.sync1 = {rxd, rx_er, rx_dv, crs, col, system_reference_clock_in, ref_clk, rx_clk,
               tx_clk_in};
    n.sync2 = s.sync1;
    n.prev = s.sync2;
    n.take = 1'b0;
    n.retry = 1'b0;
    n.abort = 1'b0;
    n.rx.valid = 1'b0;
    n.lfsr = lfsr_next(s.lfsr);

    // Equipment mode: transmit clock is half the reference rate
    if (rise(s.sync2, s.prev, `SYN_SREF))
      n.dce_clk = ~s.dce_clk;
    if (s.ctrl.dce)
      mii_step = rise(s.sync2, s.prev, `SYN_SREF) & ~s.dce_clk;
    else
      mii_step = rise(s.sync2, s.prev, `SYN_TXC);

    if (rise(s.sync2, s.prev, `SYN_REFC))
      n.div = (s.div == DIV_LAST) ? 4'h0 : s.div + 4'h1;
    ref_slot = rise(s.sync2, s.prev, `SYN_REFC) & (s.ctrl.speed100 | (s.div == 4'h0));
    step = s.ctrl.rmii ? ref_slot : mii_step;

    // Unused in full duplex
    col_hd = s.ctrl.half & s.sync2[`SYN_COL];
    crs_hd = s.ctrl.half & s.sync2[`SYN_CRS];
    jam_last = s.ctrl.rmii ? `JAM_STEPS_RMII - 5'h01 : `JAM_STEPS_MII - 5'h01;
    bo_bits = (s.attempts > `BACKOFF_LIMIT) ? `BACKOFF_LIMIT : s.attempts;
    bo_k = {8'h00, s.lfsr[9:0]} & ((18'h00001 << bo_bits) - 18'h00001);

    // ----------------------------------------
    // Transmit
    // ----------------------------------------
    case (s.tst)
      TX_IDLE:
      begin
        if (step && tx_src.valid && !crs_hd)
        begin
          n.tx.en = 1'b1;
          n.tx.d = drive(tx_src.nibble, s.ctrl.rmii, 1'b0);
          n.nib = tx_src.nibble;
          n.last = tx_src.last;
          n.phase = 1'b0;
          n.take = 1'b1;
          n.tst = TX_SEND;
        end
      end
      TX_SEND:
      begin
        if (step)
        begin
          if (col_hd)
          begin
            n.tst = TX_JAM;
            n.cnt = 18'h00000;
            n.attempts = s.attempts + 5'h01;
            n.tx.d = drive(`JAM_NIBBLE, s.ctrl.rmii, 1'b0);
          end
          else if (s.ctrl.rmii && !s.phase)
          begin
            n.phase = 1'b1;
            n.tx.d = drive(s.nib, 1'b1, 1'b1);
          end
          else if (s.last)
          begin
            n.tx.en = 1'b0;
            n.tx.d = 4'h0;
            n.attempts = 5'h00;
            n.tst = TX_IDLE;
          end
          else if (tx_src.valid)
          begin
            n.nib = tx_src.nibble;
            n.last = tx_src.last;
            n.phase = 1'b0;
            n.take = 1'b1;
            n.tx.d = drive(tx_src.nibble, s.ctrl.rmii, 1'b0);
          end
          else
          begin
            // Source ran dry mid-frame
            n.tx.en = 1'b0;
            n.tx.d = 4'h0;
            n.undr = s.undr + 32'h00000001;
            n.all = s.all + 32'h00000001;
            n.abort = 1'b1;
            n.attempts = 5'h00;
            n.tst = TX_IDLE;
          end
        end
      end
      TX_JAM:
      begin
        if (step)
        begin
          if (s.cnt[4:0] == jam_last)
          begin
            n.tx.en = 1'b0;
            n.tx.d = 4'h0;
            if (s.attempts >= ATT_MAX)
            begin
              n.all = s.all + 32'h00000001;
              n.abort = 1'b1;
              n.attempts = 5'h00;
              n.tst = TX_IDLE;
            end
            else
            begin
              // Slot of 512 bit times, counted in transmit steps
              n.cnt = s.ctrl.rmii ? bo_k << `SLOT_SHIFT_RMII
                                  : bo_k << `SLOT_SHIFT_MII;
              n.tst = TX_BACKOFF;
            end
          end
          else
          begin
            n.cnt = s.cnt + 18'h00001;
            n.tx.d = drive(`JAM_NIBBLE, s.ctrl.rmii, 1'b0);
          end
        end
      end
      TX_BACKOFF:
      begin
        if (step)
        begin
          if (s.cnt == 18'h00000)
          begin
            n.retry = 1'b1;
            n.tst = TX_IDLE;
          end
          else
            n.cnt = s.cnt - 18'h00001;
        end
      end
      default:
      begin
        n.tst = TX_IDLE;
        n.tx.en = 1'b0;
      end
    endcase

    // ----------------------------------------
    // Receive
    // ----------------------------------------
    if (s.ctrl.rmii)
    begin
      // A carrier drop between edges just ends acceptance
      if (ref_slot && s.sync2[`SYN_DV])
      begin
        n.rx.valid = 1'b1;
        n.rx.dibit = 1'b1;
        n.rx.data = {2'b00, s.sync2[`SYN_RXD+1:`SYN_RXD]};
      end
    end
    else if (rise(s.sync2, s.prev, `SYN_RXC) && s.sync2[`SYN_DV] &&
             !(s.sync2[`SYN_ER] && !s.ctrl.dce))
    begin
      n.rx.valid = 1'b1;
      n.rx.dibit = 1'b0;
      n.rx.data = s.sync2[`SYN_RXD+3:`SYN_RXD];
    end

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    if (s.wr_pend)
    begin
      if (s.wr_idx == `IDX_CTRL)
        n.ctrl = ctrl_t'(hwdata[3:0]);
      n.wr_pend = 1'b0;
    end
    if (hsel && hready && htrans[1])
    begin
      if (hwrite)
      begin
        n.wr_pend = 1'b1;
        n.wr_idx = haddr[11:2];
      end
      else
        n.rd = read_reg(haddr[11:2], s);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      s <= '0;
      s.ctrl <= ctrl_t'(`CTRL_RST);
      s.undr <= `COUNT_RST;
      s.all <= `COUNT_RST;
      s.lfsr <= `LFSR_SEED;
      s.ready <= 1'b1;
    end
    else
      s <= n;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata = s.rd;
  assign hreadyout = s.ready;
  assign hresp = s.resp;
  assign tx_clk_out = s.dce_clk;
  assign phy_tx = s.tx;
  assign tx_take = s.take;
  assign tx_retry = s.retry;
  assign tx_abort = s.abort;
  assign rx_word = s.rx;

endmodule

// ===== include/mac_port_map.svh
/*
  Register indices, reset values, field positions and link constants of the MAC port.
  Assumes inclusion by the MAC port package and module only.
*/
`ifndef MAC_PORT_MAP_SVH
`define MAC_PORT_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_UNDR_FULL 10'h334
`define IDX_UNDR_LOW 10'h337
`define IDX_ALL 10'h338
`define IDX_CTRL 10'h340
`define IDX_STATUS 10'h341

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RST 4'h0
`define COUNT_RST 32'h00000000
`define LFSR_SEED 16'hACE1

// ----------------------------------------
// Jam and backoff
// ----------------------------------------
`define JAM_NIBBLE 4'h5
`define JAM_STEPS_MII 5'h08
`define JAM_STEPS_RMII 5'h10
`define BACKOFF_LIMIT 5'h0A
`define SLOT_SHIFT_MII 7
`define SLOT_SHIFT_RMII 8

// ----------------------------------------
// Synchroniser bit positions
// ----------------------------------------
`define SYN_TXC 0
`define SYN_RXC 1
`define SYN_REFC 2
`define SYN_SREF 3
`define SYN_COL 4
`define SYN_CRS 5
`define SYN_DV 6
`define SYN_ER 7
`define SYN_RXD 8
`define SYN_W 12

`endif

// ===== include/mac_port_pkg.sv
/*
  Types of the MAC port: control word, transmit states, carrier structs, state record.
  Assumes mac_port_map.svh on the include path.
*/
`include "mac_port_map.svh"

package mac_port_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_JAM = 2'b10,
    TX_BACKOFF = 2'b11
  } tx_state_t;

  typedef struct packed {
    logic half;
    logic dce;
    logic speed100;
    logic rmii;
  } ctrl_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [3:0] nibble;
  } tx_src_t;

  typedef struct packed {
    logic en;
    logic [3:0] d;
  } phy_tx_t;

  typedef struct packed {
    logic valid;
    logic dibit;
    logic [3:0] data;
  } rx_word_t;

  typedef struct packed {
    logic [`SYN_W-1:0] sync1;
    logic [`SYN_W-1:0] sync2;
    logic [`SYN_W-1:0] prev;
    ctrl_t ctrl;
    tx_state_t tst;
    phy_tx_t tx;
    logic [3:0] nib;
    logic phase;
    logic last;
    logic [4:0] attempts;
    logic [17:0] cnt;
    logic [15:0] lfsr;
    logic [3:0] div;
    logic dce_clk;
    logic take;
    logic retry;
    logic abort;
    rx_word_t rx;
    logic [31:0] undr;
    logic [31:0] all;
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [31:0] rd;
    logic ready;
    logic resp;
  } mac_state_t;

endpackage
